//--- rtl/usfc_regs.vh
// register offsets, field positions, reset values and timing counts of the serial flow block
`ifndef USFC_REGS_VH
`define USFC_REGS_VH
// register word addresses
`define USFC_ADDR_FIFO 4'h0
`define USFC_ADDR_CTRL 4'h1
`define USFC_ADDR_TXB 4'h2
`define USFC_ADDR_RXB 4'h3
`define USFC_ADDR_IRQ_STAT 4'h4
`define USFC_ADDR_IRQ_MASK 4'h5
// fifo status fields
`define USFC_F_TX_WRITE_ERROR 7
`define USFC_F_STOP_DETECT_MODE 6
`define USFC_F_TX_BUFFER_EMPTY 5
`define USFC_F_TX_BUFFER_FULL 4
`define USFC_F_RX_PIN_IDLE 3
`define USFC_F_FLOW 2
`define USFC_F_RX_BUFFER_EMPTY 1
`define USFC_F_RX_BUFFER_FULL 0
// control fields
`define USFC_C_TRANSMIT_ENABLE 0
`define USFC_C_RUN_ON_OVERFLOW 1
`define USFC_C_FLOW_SEL_LO 2
`define USFC_C_FLOW_SEL_HI 3
`define USFC_C_RESET 8'h00
`define USFC_FLOW_SEL_SW 2'h1
// control characters
`define USFC_CHAR_SUSPEND 8'h13
`define USFC_CHAR_RESUME 8'h11
// interrupt status bits
`define USFC_I_RXDATA 0
`define USFC_I_OVF 1
`define USFC_I_TX_WRITE_ERROR 2
`define USFC_I_FLOW 3
`define USFC_I_WIDTH 4
// default bit time in clocks
`define USFC_BAUD_DIV 16'h0868
`endif

//--- rtl/usfc_core.v
// serial transmitter/receiver with software flow control and fifo status
//
// Behaviour
// - flow control select value 01 enables suspend/resume character handling
// - suspend character is 13h, resume character is 11h
// - flow state resets to resumed, transmission allowed
// - on suspend, finish current character, then start no further ones
// - stay suspended until a resume character is received
// - toggling transmit enable forces the flow state to resumed
// - with run-on-overflow set, control characters are processed regardless of buffer
// - with run-on-overflow clear, overflow suspends control character processing
// - drive-enable output steers an external line transceiver direction
// - flow state readable at fifo status bit 2, one means enabled
// - writing transmit buffer while full sets write error bit 7, software clears
// - receive idle bit 3 is one while the receive pin is idle
// - receive empty bit 1 reads one when empty, writing one flushes
`timescale 1ns/1ps
`include "usfc_regs.vh"
module usfc_core #(
  parameter DEPTH = 4,
  parameter AW = 2,
  parameter [15:0] BAUD_DIV = `USFC_BAUD_DIV
)(
  // clock and reset
  input wire clk,
  input wire srst,
  // register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // serial line
  input wire rxd,
  output reg txd,
  output reg transmit_drive_enable,
  // interrupt
  output reg irq
);
  // ==========================================================
  // state and storage
  reg rx_s1, rx_s2;
  reg [7:0] ctrl;
  reg transmit_enable_d;
  reg flow_on;
  reg tx_write_error;
  reg rx_ovf_hold;
  reg [3:0] istat, imask;
  reg [7:0] txq [0:DEPTH-1];
  reg [7:0] rxq [0:DEPTH-1];
  reg [AW:0] tx_cnt, rx_cnt;
  reg [AW-1:0] tx_rp, tx_wp, rx_rp, rx_wp;
  reg [15:0] btick_cnt;
  reg [3:0] tx_bit;
  reg [9:0] tx_sh;
  reg tx_busy;
  reg [15:0] rx_tcnt;
  reg [3:0] rx_bit;
  reg [7:0] rx_sh;
  reg rx_busy;
  wire sel_sw = ctrl[`USFC_C_FLOW_SEL_HI:`USFC_C_FLOW_SEL_LO] == `USFC_FLOW_SEL_SW;
  wire tx_full = tx_cnt == DEPTH;
  wire tx_empty = tx_cnt == 0;
  wire rx_full = rx_cnt == DEPTH;
  wire rx_empty = rx_cnt == 0;
  wire btick = btick_cnt == BAUD_DIV - 16'h0001;
  wire fifo_wr = wr && addr == `USFC_ADDR_FIFO;
  wire ctrl_wr = wr && addr == `USFC_ADDR_CTRL;
  wire txb_wr = wr && addr == `USFC_ADDR_TXB;
  wire rxb_rd = rd && addr == `USFC_ADDR_RXB;
  wire rx_flush = fifo_wr && wdata[`USFC_F_RX_BUFFER_EMPTY];
  wire tx_discard = fifo_wr && wdata[`USFC_F_TX_BUFFER_EMPTY];
  wire tx_push = txb_wr && !tx_full;
  wire tx_start = tx_busy == 1'b0 && !tx_empty && ctrl[`USFC_C_TRANSMIT_ENABLE] && flow_on
                  && btick;
  wire rx_done = rx_busy && rx_bit == 4'h9 && rx_tcnt == BAUD_DIV - 16'h0001;
  wire rx_stop_ok = rx_done && rx_s2;
  wire rx_push = rx_stop_ok && !rx_full && !rx_flush;
  wire rx_ovf = rx_stop_ok && rx_full;
  wire rx_pop = rxb_rd && !rx_empty && !rx_flush;
  // control characters count only while processing is allowed
  wire flow_live = sel_sw && (ctrl[`USFC_C_RUN_ON_OVERFLOW] || !rx_ovf_hold);
  wire got_suspend = rx_stop_ok && flow_live && rx_sh == `USFC_CHAR_SUSPEND;
  wire got_resume = rx_stop_ok && flow_live && rx_sh == `USFC_CHAR_RESUME;
  wire transmit_enable_toggle = ctrl[`USFC_C_TRANSMIT_ENABLE] != transmit_enable_d;
  // status shows the forced state already in the cycle before flow_on follows
  wire flow_seen = flow_on || !sel_sw || transmit_enable_toggle;
  wire [3:0] ev;
  assign ev = {got_suspend | got_resume, txb_wr & tx_full, rx_ovf, rx_push};

  // ==========================================================
  // receive pin synchroniser
  always @(posedge clk)
  begin
    if (srst)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end
    else
    begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
    end
  end

  // ==========================================================
  // control, flow state and error flags
  always @(posedge clk)
  begin
    if (srst)
    begin
      ctrl <= `USFC_C_RESET;
      transmit_enable_d <= 1'b0;
      flow_on <= 1'b1;
      tx_write_error <= 1'b0;
      rx_ovf_hold <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
        ctrl <= wdata;
      transmit_enable_d <= ctrl[`USFC_C_TRANSMIT_ENABLE];
      // flow state update
      if (!sel_sw || transmit_enable_toggle)
        flow_on <= 1'b1;
      else if (got_suspend)
        flow_on <= 1'b0;
      else if (got_resume)
        flow_on <= 1'b1;
      // write error: set wins over software clear
      if (txb_wr && tx_full)
        tx_write_error <= 1'b1;
      else if (fifo_wr && !wdata[`USFC_F_TX_WRITE_ERROR])
        tx_write_error <= 1'b0;
      // overflow holds processing off until the next buffer read or flush
      if (rx_ovf)
        rx_ovf_hold <= 1'b1;
      else if (rx_flush || rx_pop)
        rx_ovf_hold <= 1'b0;
    end
  end

  // ==========================================================
  // bit rate divider
  always @(posedge clk)
  begin
    if (srst || btick)
      btick_cnt <= 16'h0000;
    else
      btick_cnt <= btick_cnt + 16'h0001;
  end

  // ==========================================================
  // transmit queue and shifter
  always @(posedge clk)
  begin
    if (srst)
    begin
      tx_cnt <= {(AW+1){1'b0}};
      tx_rp <= {AW{1'b0}};
      tx_wp <= {AW{1'b0}};
      tx_busy <= 1'b0;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3FF;
      txd <= 1'b1;
      transmit_drive_enable <= 1'b0;
    end
    else
    begin
      if (tx_push)
      begin
        txq[tx_wp] <= wdata;
        tx_wp <= tx_wp + 1'b1;
      end
      if (tx_discard)
      begin
        tx_busy <= 1'b0;
        txd <= 1'b1;
        transmit_drive_enable <= 1'b0;
      end
      else if (tx_start)
      begin
        tx_sh <= {1'b1, txq[tx_rp], 1'b0};
        tx_rp <= tx_rp + 1'b1;
        tx_busy <= 1'b1;
        tx_bit <= 4'h0;
        transmit_drive_enable <= 1'b1;
        txd <= 1'b0;
      end
      else if (tx_busy && btick)
      begin
        if (tx_bit == 4'h9)
        begin
          tx_busy <= 1'b0;
          transmit_drive_enable <= 1'b0;
          txd <= 1'b1;
        end
        else
        begin
          tx_bit <= tx_bit + 4'h1;
          txd <= tx_sh[tx_bit + 4'h1];
        end
      end
      tx_cnt <= tx_cnt + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_start && !tx_discard};
    end
  end

  // ==========================================================
  // receive shifter and queue
  always @(posedge clk)
  begin
    if (srst)
    begin
      rx_busy <= 1'b0;
      rx_tcnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_cnt <= {(AW+1){1'b0}};
      rx_rp <= {AW{1'b0}};
      rx_wp <= {AW{1'b0}};
    end
    else
    begin
      if (!rx_busy)
      begin
        if (!rx_s2)
        begin
          rx_busy <= 1'b1;
          rx_tcnt <= BAUD_DIV >> 1;
          rx_bit <= 4'h0;
        end
      end
      else if (rx_tcnt == BAUD_DIV - 16'h0001)
      begin
        rx_tcnt <= 16'h0000;
        if (rx_bit == 4'h0 && rx_s2)
          rx_busy <= 1'b0;
        else if (rx_bit == 4'h9)
          rx_busy <= 1'b0;
        else
        begin
          if (rx_bit != 4'h0)
            rx_sh <= {rx_s2, rx_sh[7:1]};
          rx_bit <= rx_bit + 4'h1;
        end
      end
      else
        rx_tcnt <= rx_tcnt + 16'h0001;
      if (rx_push)
      begin
        rxq[rx_wp] <= rx_sh;
        rx_wp <= rx_wp + 1'b1;
      end
      if (rx_pop)
        rx_rp <= rx_rp + 1'b1;
      if (rx_flush)
      begin
        rx_cnt <= {(AW+1){1'b0}};
        rx_rp <= rx_wp;
      end
      else
        rx_cnt <= rx_cnt + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};
    end
  end

  // ==========================================================
  // interrupt status, mask and output
  always @(posedge clk)
  begin
    if (srst)
    begin
      istat <= 4'h0;
      imask <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr && addr == `USFC_ADDR_IRQ_MASK)
        imask <= wdata[3:0];
      if (wr && addr == `USFC_ADDR_IRQ_STAT)
        istat <= (istat & ~wdata[3:0]) | ev;
      else
        istat <= istat | ev;
      irq <= |(istat & imask);
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always @(posedge clk)
  begin
    if (srst)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `USFC_ADDR_FIFO:
          rdata <= {tx_write_error, 1'b0, tx_empty && !tx_busy, tx_full,
                    !rx_busy && rx_s2, flow_seen, rx_empty, rx_full};
        `USFC_ADDR_CTRL: rdata <= ctrl;
        `USFC_ADDR_RXB: rdata <= rx_empty ? 8'h00 : rxq[rx_rp];
        `USFC_ADDR_IRQ_STAT: rdata <= {4'h0, istat};
        `USFC_ADDR_IRQ_MASK: rdata <= {4'h0, imask};
        default: rdata <= 8'h00;
      endcase
    end
  end
endmodule

//--- dv/usfc_core_assertions.sv
// port checker for the serial flow block
`timescale 1ns/1ps
module usfc_checker (
  // clock and reset
  input wire clk,
  input wire srst,
  // register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  // serial and irq
  input wire txd,
  input wire transmit_drive_enable,
  input wire irq
);
  reg [1:0] flow_sel;
  reg [7:0] msk;
  wire tde = transmit_drive_enable;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // ====================
  // shadow of flow select and irq mask
  always @(posedge clk)
  begin
    if (srst)
    begin
      flow_sel <= 2'h0;
      msk <= 8'h00;
    end
    else if (wr && addr == 4'h1)
      flow_sel <= wdata[3:2];
    else if (wr && addr == 4'h5)
      msk <= wdata;
  end
  // start bit, then drive held
  sequence s_frame;
    !txd ##1 tde [*8];
  endsequence
  AST_IDLE: assert property (!tde |-> txd)
    else $error("txd low while idle");
  AST_FRAME: assert property ($rose(tde) |-> s_frame)
    else $error("bad frame start");
  AST_STOP: assert property ($fell(tde) |-> $past(txd))
    else $error("no stop bit");
  AST_RST: assert property ($fell(srst) |-> txd && !tde && !irq)
    else $error("outputs busy after reset");
  AST_HOLD: assert property (!$past(rd) |-> $stable(rdata))
    else $error("rdata moved");
  AST_UNMAP: assert property (rd && addr > 4'h5 |=> rdata == 8'h00)
    else $error("unmapped read nonzero");
  AST_FLOW_OFF: assert property (rd && addr == 4'h0 && flow_sel != 2'h1 |=> rdata[2])
    else $error("flow not held on");
  AST_MASK: assert property (msk == 8'h00 && $past(msk) == 8'h00 |-> !irq)
    else $error("irq while masked");
  AST_DISCARD: assert property (wr && addr == 4'h0 && wdata[5] |=> !tde)
    else $error("drive still on after discard");
endmodule

// ====================
bind usfc_core usfc_checker u_usfc_checker (.clk(clk), .srst(srst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .txd(txd),
  .transmit_drive_enable(transmit_drive_enable), .irq(irq));

//--- dv/usfc_remote.sv
// remote serial node model
`timescale 1ns/1ps
module usfc_remote #(
  parameter int BIT = 8
) (
  // clock and serial lines
  input wire clk,
  input wire txd,
  output logic rxd,
  // received byte strobe
  output logic got,
  output logic [7:0] got_byte
);
  initial
  begin
    rxd = 1'b1;
    got = 1'b0;
    got_byte = 8'h00;
  end
  // send one frame, lsb first
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // take frames off txd at mid bit
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clk);
      got_byte[i] <= txd;
    end
    repeat (BIT) @(posedge clk);
    got <= 1'b1;
    @(posedge clk);
    got <= 1'b0;
  end
endmodule

//--- dv/tb.sv
// testbench for the serial flow block
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  wire [7:0] rdata;
  wire rxd;
  wire txd;
  wire transmit_drive_enable;
  wire irq;
  wire got;
  wire [7:0] got_byte;
  int failures = 0;
  int check_count = 0;
  integer seed = 32'h24F82DF8;
  logic [7:0] b1;
  logic [15:0] e;
  logic [15:0] exp_rd[$];
  logic [7:0] exp_tx[$];
  usfc_core #(.DEPTH(4), .AW(2), .BAUD_DIV(16'h0008)) u_usfc_core (.clk(clk), .srst(srst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd),
    .transmit_drive_enable(transmit_drive_enable), .irq(irq));
  usfc_remote #(.BIT(8)) u_usfc_remote (.clk(clk), .txd(txd), .rxd(rxd), .got(got),
    .got_byte(got_byte));
  always #2 clk = ~clk;
  // ====================
  // helpers
  task automatic check(input string nm, input logic [7:0] s, input logic [7:0] x);
    check_count++;
    if (s !== x)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
    exp_rd.push_back({m, v});
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic send(input logic [7:0] d);
    u_usfc_remote.send(d);
    repeat (10) @(posedge clk);
  endtask
  function automatic logic [7:0] rnd();
    return 8'h40 | (8'h3F & $random(seed));
  endfunction
  // count drive cycles over a quiet stretch
  task automatic quiet;
    int n;
    n = 0;
    repeat (200)
    begin
      @(negedge clk);
      n += transmit_drive_enable;
    end
    check("drive", n[7:0], 8'h00);
    @(posedge clk);
  endtask
  task automatic chk_irq(input logic v);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("irq", {7'h00, irq}, {7'h00, v});
    @(posedge clk);
  endtask
  // compare results with the oldest notes
  always @(posedge clk)
  begin
    rd_d <= rd;
    if (rd_d)
    begin
      e = exp_rd.pop_front();
      check("rdata", rdata & e[15:8], e[7:0]);
    end
    if (got)
      check("txbyte", got_byte, exp_tx.pop_front());
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    final_report();
  end
  // ====================
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd_reg(4'h0, 8'hFF, 8'h2E);
    rd_reg(4'hF, 8'hFF, 8'h00);
    $display("test reset done");
    wr_reg(4'h1, 8'h01);
    b1 = rnd();
    send(b1);
    rd_reg(4'h0, 8'h02, 8'h00);
    rd_reg(4'h3, 8'hFF, b1);
    fork
      send(rnd());
      begin
        repeat (30) @(posedge clk);
        rd_reg(4'h0, 8'h08, 8'h00);
      end
    join
    wr_reg(4'h0, 8'h02);
    rd_reg(4'h0, 8'h0A, 8'h0A);
    send(8'h13);
    rd_reg(4'h0, 8'h04, 8'h04);
    $display("test receive done");
    wr_reg(4'h1, 8'h05);
    send(8'h13);
    rd_reg(4'h0, 8'h04, 8'h00);
    b1 = rnd();
    wr_reg(4'h2, b1);
    quiet();
    exp_tx.push_back(b1);
    send(8'h11);
    repeat (100) @(posedge clk);
    rd_reg(4'h0, 8'h04, 8'h04);
    exp_tx.push_back(rnd());
    exp_tx.push_back(rnd());
    fork
      send(8'h13);
      begin
        repeat (40) @(posedge clk);
        wr_reg(4'h2, exp_tx[0]);
        wr_reg(4'h2, exp_tx[1]);
      end
    join
    repeat (50) @(posedge clk);
    quiet();
    send(8'h11);
    repeat (100) @(posedge clk);
    $display("test suspend done");
    wr_reg(4'h0, 8'h02);
    send(8'h13);
    rd_reg(4'h0, 8'h04, 8'h00);
    wr_reg(4'h1, 8'h04);
    wr_reg(4'h1, 8'h05);
    rd_reg(4'h0, 8'h04, 8'h04);
    $display("test toggle done");
    wr_reg(4'h0, 8'h02);
    repeat (6) send(rnd());
    send(8'h13);
    rd_reg(4'h0, 8'h05, 8'h05);
    wr_reg(4'h0, 8'h02);
    wr_reg(4'h1, 8'h07);
    repeat (6) send(rnd());
    send(8'h13);
    rd_reg(4'h0, 8'h04, 8'h00);
    $display("test overflow done");
    repeat (6) wr_reg(4'h2, rnd());
    rd_reg(4'h0, 8'h90, 8'h90);
    wr_reg(4'h5, 8'h04);
    chk_irq(1'b1);
    wr_reg(4'h5, 8'h00);
    chk_irq(1'b0);
    wr_reg(4'h5, 8'h04);
    wr_reg(4'h4, 8'h04);
    chk_irq(1'b0);
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h0, 8'h20);
    rd_reg(4'h0, 8'h80, 8'h00);
    $display("test write error done");
    final_report();
  end
endmodule
